// *** src/tcc_top.sv ***
// Timer channel: command and mode logic, counter, capture and waveform
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
module tcc_top (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        line_a_in,
   output logic             line_a_out,
   output logic             line_a_oe,
   input  wire logic        line_b_in,
   output logic             line_b_out,
   output logic             line_b_oe,
   input  wire logic        ext_clock_in0,
   input  wire logic        ext_clock_in1,
   input  wire logic        ext_clock_in2
);
   logic [4:0]  pin_lvl;
   logic [4:0]  pin_rise;
   logic [4:0]  pin_fall;
   logic [4:0]  int_rise;
   logic [4:0]  int_fall;
   logic        pready_q;
   logic        pslverr_q;
   logic [31:0] prdata_q;
   logic [31:0] mode_q;
   logic [15:0] cnt_q;
   logic [15:0] cnt_d;
   logic [15:0] ra_q;
   logic [15:0] rb_q;
   logic [15:0] rc_q;
   logic        dn_q;
   logic        dn_d;
   logic        clk_en_q;
   logic        clk_en_d;
   logic        clk_stop_q;
   logic        clk_stop_d;
   logic        cmp_a_q;
   logic        cmp_b_q;
   logic        cmp_c_q;
   logic        a_out_q;
   logic        b_out_q;
   logic        a_oe_q;
   logic        b_oe_q;

   // Pin order: 0 line A, 1 line B, 2..4 external clocks
   tcc_sync u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .d       ({ext_clock_in2, ext_clock_in1, ext_clock_in0, line_b_in, line_a_in}),
      .lvl     (pin_lvl),
      .rise    (pin_rise),
      .fall    (pin_fall)
   );

   tcc_presc u_presc (
      .pclk    (pclk),
      .presetn (presetn),
      .rise    (int_rise),
      .fall    (int_fall)
   );

   function automatic logic edge_hit(input logic [1:0] sel, input logic r, input logic f);
      return (sel[0] & r) | (sel[1] & f);
   endfunction : edge_hit

   // Later entries of hit carry higher priority: software, event, C, A/B
   function automatic logic out_next(input logic cur, input logic [3:0] hit,
                                     input logic [7:0] eff);
      logic [1:0] e;
      logic       v;
      e = 2'b00;
      for (int i = 0; i < 4; i++)
         if (hit[i])
            e = eff[2*i +: 2];
      unique case (tcc_pkg::tcc_eff_t'(e))
         tcc_pkg::EFF_NONE: v = cur;
         tcc_pkg::EFF_SET:  v = 1'b1;
         tcc_pkg::EFF_CLR:  v = 1'b0;
         tcc_pkg::EFF_TGL:  v = ~cur;
      endcase
      return v;
   endfunction : out_next

   // Bus decode; one wait state so every bus output can come from a flop
   wire apb_acc  = psel & penable;
   wire acc_new  = apb_acc & ~pready_q;
   wire sel_cmd  = paddr == tcc_pkg::ADDR_CMD;
   wire sel_mode = paddr == tcc_pkg::ADDR_MODE;
   wire sel_cnt  = paddr == tcc_pkg::ADDR_CNT;
   wire sel_ra   = paddr == tcc_pkg::ADDR_RA;
   wire sel_rb   = paddr == tcc_pkg::ADDR_RB;
   wire sel_rc   = paddr == tcc_pkg::ADDR_RC;
   wire sel_stat = paddr == tcc_pkg::ADDR_STAT;
   wire wave     = mode_q[tcc_pkg::M_WAVE];
   wire addr_ok  = sel_cmd | sel_mode | sel_cnt | sel_ra | sel_rb | sel_rc | sel_stat;
   wire ro_hit   = sel_cnt | sel_stat | (~wave & (sel_ra | sel_rb));
   wire bad_acc  = ~addr_ok | (pwrite & ro_hit);
   wire wr_ok    = apb_acc & pready_q & pwrite & ~pslverr_q;

   wire sw_trg   = wr_ok & sel_cmd & pwdata[tcc_pkg::CMD_SOFT_TRIGGER_CMD];
   wire en_cmd   = wr_ok & sel_cmd & pwdata[tcc_pkg::CMD_CLOCK_ENABLE_CMD];
   wire dis_cmd  = wr_ok & sel_cmd & pwdata[tcc_pkg::CMD_CLOCK_DISABLE_CMD];

   // Mode fields, shared bits read per operation
   wire [2:0] clk_sel  = mode_q[tcc_pkg::M_CLKSEL +: 3];
   wire       clk_inv  = mode_q[tcc_pkg::M_INV];
   wire [1:0] burst    = mode_q[tcc_pkg::M_BURST +: 2];
   wire       stop_bit = mode_q[tcc_pkg::M_STOP];
   wire       dis_bit  = mode_q[tcc_pkg::M_DIS];
   wire [1:0] tedg     = mode_q[tcc_pkg::M_TEDG +: 2];
   wire [1:0] tsel     = mode_q[tcc_pkg::M_TSEL +: 2];
   wire [1:0] waveform_shape_sel   = mode_q[tcc_pkg::M_WAVEFORM_SHAPE_SEL +: 2];
   wire       updown   = wave & waveform_shape_sel[0];
   wire       b_is_out = wave & (tsel != 2'd0);

   // Counter clock: selected edge, gated by the burst input
   wire [7:0] src_rise = {pin_rise[4:2], int_rise};
   wire [7:0] src_fall = {pin_fall[4:2], int_fall};
   wire       src_edge = clk_inv ? src_fall[clk_sel] : src_rise[clk_sel];
   wire [2:0] burst_ix = {1'b0, burst} + 3'd1;
   wire       gate_ok  = (burst == 2'd0) | pin_lvl[burst_ix];
   wire       run      = clk_en_q & ~clk_stop_q;
   wire       tick     = run & src_edge & gate_ok;

   // Capture sources
   wire [2:0] trg_ix  = tsel[0] ? 3'd0 : 3'd1;
   wire       cap_ext = ~wave & edge_hit(tedg, pin_rise[trg_ix], pin_fall[trg_ix]);
   wire       load_a  = ~wave & edge_hit(mode_q[tcc_pkg::M_CAPTURE_A_EDGE_SEL +: 2], pin_rise[0],
                                         pin_fall[0]);
   wire       load_b  = ~wave & edge_hit(mode_q[tcc_pkg::M_CAPTURE_B_EDGE_SEL +: 2], pin_rise[0],
                                         pin_fall[0]);

   // Waveform external event; index 1 is line B, 2..4 the external clocks
   wire [2:0] ev_ix   = {1'b0, tsel} + 3'd1;
   wire       wave_ev = wave & edge_hit(tedg, pin_rise[ev_ix], pin_fall[ev_ix]);
   wire       ext_trg = wave ? wave_ev & mode_q[tcc_pkg::M_EVENT_TRIGGER_EN] : cap_ext;
   wire       cmpc_trg = cmp_c_q & (wave ? waveform_shape_sel[1] : mode_q[tcc_pkg::M_COMPARE_C_TRIGGER_EN]);
   wire       trig    = sw_trg | ext_trg | cmpc_trg;

   // Up-down turns at 0xffff or at compare C depending on shape
   wire [15:0] top_v  = waveform_shape_sel[1] ? rc_q : tcc_pkg::CNT_TOP;
   wire        at_top = cnt_q == top_v;
   wire        at_bot = cnt_q == tcc_pkg::CNT_RST;
   wire        go_dn  = updown & (dn_q ? ~at_bot : at_top);
   wire [15:0] stepped = go_dn ? cnt_q - 16'h1 : cnt_q + 16'h1;
   // Compare C auto-turn is handled by the count itself, not a second reversal
   wire        flip   = updown & (sw_trg | ext_trg);

   always_comb
   begin
      cnt_d = cnt_q;
      dn_d  = dn_q;
      if (trig & ~updown)
      begin
         cnt_d = tcc_pkg::CNT_RST;
         dn_d  = 1'b0;
      end
      else if (flip)
         dn_d = ~dn_q;
      else if (tick)
      begin
         cnt_d = stepped;
         dn_d  = go_dn;
      end
   end

   // Disable beats enable; stop beats restart in the same cycle
   wire dis_ev  = dis_cmd | (dis_bit & (wave ? cmp_c_q : load_b));
   wire stop_ev = stop_bit & (wave ? cmp_c_q : load_b);
   assign clk_en_d   = dis_ev ? 1'b0 : (en_cmd ? 1'b1 : clk_en_q);
   assign clk_stop_d = stop_ev ? 1'b1 : ((trig | en_cmd) ? 1'b0 : clk_stop_q);

   wire cmp_ok = tick & ~trig & ~flip;
   wire [3:0] hit_a = {sw_trg, wave_ev, cmp_c_q, cmp_a_q};
   wire [3:0] hit_b = {sw_trg, wave_ev, cmp_c_q, cmp_b_q};

   wire [31:0] stat_v = 32'(clk_en_q) << tcc_pkg::ST_CLKSTA
                      | 32'(wave ? a_out_q : pin_lvl[0]) << tcc_pkg::ST_MIRA
                      | 32'(b_is_out ? b_out_q : pin_lvl[1]) << tcc_pkg::ST_MIRB
                      | 32'(clk_stop_q) << tcc_pkg::ST_STOP;
   wire [31:0] rd_v = sel_mode ? mode_q :
                      sel_cnt  ? {16'h0, cnt_q} :
                      sel_ra   ? {16'h0, ra_q} :
                      sel_rb   ? {16'h0, rb_q} :
                      sel_rc   ? {16'h0, rc_q} :
                      sel_stat ? stat_v : 32'h0;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0;
      end
      else
      begin
         pready_q  <= acc_new;
         pslverr_q <= acc_new & bad_acc;
         if (acc_new)
            prdata_q <= pwrite ? 32'h0 : rd_v;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mode_q <= tcc_pkg::MODE_RST;
         rc_q   <= tcc_pkg::CNT_RST;
      end
      else
      begin
         if (wr_ok & sel_mode)
            mode_q <= pwdata;
         if (wr_ok & sel_rc)
            rc_q <= pwdata[15:0];
      end
   end

   // Loads win over a write in the same cycle: hardware state must not be lost
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ra_q <= tcc_pkg::CNT_RST;
         rb_q <= tcc_pkg::CNT_RST;
      end
      else
      begin
         if (load_a)
            ra_q <= cnt_q;
         else if (wr_ok & sel_ra)
            ra_q <= pwdata[15:0];
         if (load_b)
            rb_q <= cnt_q;
         else if (wr_ok & sel_rb)
            rb_q <= pwdata[15:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt_q      <= tcc_pkg::CNT_RST;
         dn_q       <= 1'b0;
         clk_en_q   <= 1'b0;
         clk_stop_q <= 1'b0;
         cmp_a_q    <= 1'b0;
         cmp_b_q    <= 1'b0;
         cmp_c_q    <= 1'b0;
      end
      else
      begin
         cnt_q      <= cnt_d;
         dn_q       <= dn_d;
         clk_en_q   <= clk_en_d;
         clk_stop_q <= clk_stop_d;
         cmp_a_q    <= cmp_ok & (stepped == ra_q);
         cmp_b_q    <= cmp_ok & (stepped == rb_q) & b_is_out;
         cmp_c_q    <= cmp_ok & (stepped == rc_q);
      end
   end

   // Output controller; line B drives nothing when it is the event input
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         a_out_q <= 1'b0;
         b_out_q <= 1'b0;
         a_oe_q  <= 1'b0;
         b_oe_q  <= 1'b0;
      end
      else
      begin
         a_oe_q <= wave;
         b_oe_q <= b_is_out;
         if (wave)
            a_out_q <= out_next(a_out_q, hit_a, mode_q[tcc_pkg::M_EFF_A +: 8]);
         if (b_is_out)
            b_out_q <= out_next(b_out_q, hit_b, mode_q[tcc_pkg::M_EFF_B +: 8]);
      end
   end

   assign prdata     = prdata_q;
   assign pready     = pready_q;
   assign pslverr    = pslverr_q;
   assign line_a_out = a_out_q;
   assign line_a_oe  = a_oe_q;
   assign line_b_out = b_out_q;
   assign line_b_oe  = b_oe_q;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_soft_trigger_cmd_resets: assert property (
      sw_trg & ~updown |=> cnt_q == 16'h0000 && !clk_stop_q)
      else $error("software trigger did not reset the counter");
   a_clock_disable_cmd_off: assert property (
      dis_cmd |=> !clk_en_q ##1 (!clk_en_q || $past(en_cmd)))
      else $error("disable command did not turn the clock off");
   a_clock_enable_cmd_on: assert property (
      en_cmd & ~dis_ev |=> clk_en_q)
      else $error("enable command did not turn the clock on");
   a_load_a_value: assert property (
      load_a |=> ra_q == $past(cnt_q))
      else $error("register A did not capture the counter");
   a_load_b_dis: assert property (
      ~wave & load_b & dis_bit |=> !clk_en_q)
      else $error("register B load did not disable the clock");
   a_cmpc_stop: assert property (
      wave & cmp_c_q & stop_bit |=> clk_stop_q)
      else $error("compare C did not stop the clock");
   a_idle_holds: assert property (
      !run & !trig & !flip |=> $stable(cnt_q))
      else $error("counter moved with its clock off");
   a_line_b_input: assert property (
      wave & (tsel == 2'd0) |=> !line_b_oe)
      else $error("line B driven while selected as event input");
   a_updown_peak: assert property (
      updown & tick & ~dn_q & at_top & ~trig & ~flip
      |=> dn_q && cnt_q == $past(cnt_q) - 16'h1)
      else $error("up-down counter did not turn at full count");
   a_sw_sets_a: assert property (
      wave & sw_trg & (mode_q[23:22] == 2'd1) |=> line_a_out)
      else $error("software trigger did not set line A");

   c_wave_soft_trigger_cmd: cover property (wave & sw_trg);
   c_capture_b: cover property (load_b ##1 rb_q != 16'h0);
   c_updown_turn: cover property (updown & tick & go_dn & ~dn_q);
endmodule : tcc_top

// *** src/tcc_pkg.sv ***
// Package: register map, field positions and constants of one timer channel
package tcc_pkg;
// Behaviour
// - Command bit 2 written one resets the counter and starts its clock.
// - Command bit 1 written one disables the counter clock; zero does nothing.
// - Command bit 0 written one enables the clock unless bit 1 is also one.
// - Mode bit 15 selects capture (0) or waveform (1) meaning of the fields.
// - Capture: line A edge that loads register B: none, rise, fall, both.
// - Capture: line A edge that loads register A, same encoding.
// - Capture: compare C resets and starts the counter when enabled.
// - Capture: external trigger comes from line A when one, line B when zero.
// - Capture: trigger edge none, rising, falling or both.
// - Capture: register B load disables the clock when so configured.
// - Capture: register B load stops the clock when so configured.
// - Burst field ANDs the counter clock with external clock 0, 1 or 2.
// - Clock select 0-4 internal, 5-7 external; invert counts on falling edge.
// - Waveform shape: up, up-down, up with C trigger, up-down with C trigger.
// - Software, event, compare C, compare B set/clear/toggle line B.
// - Software, event, compare C, compare A set/clear/toggle line A.
// - Enabled external event resets the counter and starts its clock.
// - Disabled event trigger leaves counter alone and only drives lines A and B.
// - Event source line B or external clocks; line B then becomes an input.
// - Waveform: event edge none, rising, falling or both.
// - Waveform: reaching compare C disables the clock when so configured.
// - Waveform: reaching compare C stops the clock when so configured.
// - Up-down without C trigger counts 0 to 0xffff and back, repeating.
// - Up-down: a trigger reverses the counting direction.
   localparam logic [7:0] ADDR_CMD  = 8'h00;
   localparam logic [7:0] ADDR_MODE = 8'h04;
   localparam logic [7:0] ADDR_CNT  = 8'h10;
   localparam logic [7:0] ADDR_RA   = 8'h14;
   localparam logic [7:0] ADDR_RB   = 8'h18;
   localparam logic [7:0] ADDR_RC   = 8'h1c;
   localparam logic [7:0] ADDR_STAT = 8'h20;
   localparam int CMD_CLOCK_ENABLE_CMD  = 0;
   localparam int CMD_CLOCK_DISABLE_CMD = 1;
   localparam int CMD_SOFT_TRIGGER_CMD  = 2;
   localparam int M_CLKSEL = 0;
   localparam int M_INV    = 3;
   localparam int M_BURST  = 4;
   localparam int M_STOP   = 6;
   localparam int M_DIS    = 7;
   localparam int M_TEDG   = 8;
   localparam int M_TSEL   = 10;
   localparam int M_EVENT_TRIGGER_EN = 12;
   localparam int M_WAVEFORM_SHAPE_SEL = 13;
   localparam int M_COMPARE_C_TRIGGER_EN = 14;
   localparam int M_WAVE   = 15;
   localparam int M_CAPTURE_A_EDGE_SEL   = 16;
   localparam int M_CAPTURE_B_EDGE_SEL   = 18;
   localparam int M_EFF_A  = 16;
   localparam int M_EFF_B  = 24;
   localparam int ST_CLKSTA = 16;
   localparam int ST_MIRA   = 17;
   localparam int ST_MIRB   = 18;
   localparam int ST_STOP   = 19;
   localparam logic [31:0] MODE_RST = 32'h0000_0000;
   localparam logic [15:0] CNT_RST  = 16'h0000;
   localparam logic [15:0] CNT_TOP  = 16'hffff;
   localparam int PIN_N   = 5;
   localparam int PRESC_W = 10;
   localparam int DIV_BITS [5] = '{0, 2, 4, 6, 9};
   typedef enum logic [1:0] {EFF_NONE, EFF_SET, EFF_CLR, EFF_TGL} tcc_eff_t;
endpackage : tcc_pkg

// *** src/tcc_sync.sv ***
// Pin synchroniser with level and edge pulses
`timescale 1ns/1ps
module tcc_sync (
   input  wire logic                    pclk,
   input  wire logic                    presetn,
   input  wire logic [tcc_pkg::PIN_N-1:0] d,
   output logic [tcc_pkg::PIN_N-1:0]      lvl,
   output logic [tcc_pkg::PIN_N-1:0]      rise,
   output logic [tcc_pkg::PIN_N-1:0]      fall
);
   logic [tcc_pkg::PIN_N-1:0] meta_q;
   logic [tcc_pkg::PIN_N-1:0] sync_q;
   logic [tcc_pkg::PIN_N-1:0] last_q;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         meta_q <= '0;
         sync_q <= '0;
         last_q <= '0;
      end
      else
      begin
         meta_q <= d;
         sync_q <= meta_q;
         last_q <= sync_q;
      end
   end

   assign lvl  = sync_q;
   assign rise = sync_q & ~last_q;
   assign fall = ~sync_q & last_q;
endmodule : tcc_sync

// *** src/tcc_presc.sv ***
// Prescaler making the five internal timer clock edge enables
`timescale 1ns/1ps
module tcc_presc (
   input  wire logic       pclk,
   input  wire logic       presetn,
   output logic [4:0]      rise,
   output logic [4:0]      fall
);
   logic [tcc_pkg::PRESC_W-1:0] cnt_q;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cnt_q <= '0;
      else
         cnt_q <= cnt_q + 10'h1;
   end

   for (genvar i = 0; i < 5; i++)
   begin : g_div
      localparam logic [9:0] MASK = 10'((1 << tcc_pkg::DIV_BITS[i]) - 1);
      logic rise_q;
      logic fall_q;
      wire  wrap = (cnt_q & MASK) == MASK;
      always_ff @(posedge pclk or negedge presetn)
      begin
         if (!presetn)
         begin
            rise_q <= 1'b0;
            fall_q <= 1'b0;
         end
         else
         begin
            rise_q <= wrap & ~cnt_q[tcc_pkg::DIV_BITS[i]];
            fall_q <= wrap & cnt_q[tcc_pkg::DIV_BITS[i]];
         end
      end
      assign rise[i] = rise_q;
      assign fall[i] = fall_q;
   end
endmodule : tcc_presc

// *** test/tcc_pins.sv ***
// Far-side model of the channel lines and the external clock inputs
`timescale 1ns/1ps
module tcc_pins (
   input  wire logic pclk,
   input  wire logic line_a_out,
   input  wire logic line_a_oe,
   input  wire logic line_b_out,
   input  wire logic line_b_oe,
   output logic      line_a_in,
   output logic      line_b_in,
   output logic      ext_clock_in0,
   output logic      ext_clock_in1,
   output logic      ext_clock_in2
);
   logic       a_drv;
   logic       b_drv;
   logic [2:0] x_drv;
   initial
   begin
      a_drv = 1'b0;
      b_drv = 1'b0;
      x_drv = 3'h0;
   end
   // A driven pin shows the device level; otherwise this side drives it
   assign line_a_in     = line_a_oe ? line_a_out : a_drv;
   assign line_b_in     = line_b_oe ? line_b_out : b_drv;
   assign ext_clock_in0 = x_drv[0];
   assign ext_clock_in1 = x_drv[1];
   assign ext_clock_in2 = x_drv[2];
   task automatic set_a(input logic v);
      @(posedge pclk);
      a_drv <= v;
   endtask : set_a
   // Half period h must be at least one pclk cycle for the synchroniser
   task automatic pulse_x(input int i, input int n, input int h);
      repeat (n)
      begin
         @(posedge pclk);
         x_drv[i] <= 1'b1;
         repeat (h) @(posedge pclk);
         x_drv[i] <= 1'b0;
         repeat (h) @(posedge pclk);
      end
   endtask : pulse_x
endmodule : tcc_pins

// *** test/tcc_top_tb.sv ***
// Self-checking bench of the timer channel command and mode logic
`timescale 1ns/1ps
module tcc_top_tb;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        line_a_in;
   logic        line_a_out;
   logic        line_a_oe;
   logic        line_b_in;
   logic        line_b_out;
   logic        line_b_oe;
   logic        ext_clock_in0;
   logic        ext_clock_in1;
   logic        ext_clock_in2;
   logic [31:0] rdat;
   logic        rerr;
   logic        ea;
   int          err_total;
   int          n_tests;
   int          cycles;

   tcc_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .line_a_in(line_a_in), .line_a_out(line_a_out),
      .line_a_oe(line_a_oe), .line_b_in(line_b_in), .line_b_out(line_b_out),
      .line_b_oe(line_b_oe), .ext_clock_in0(ext_clock_in0),
      .ext_clock_in1(ext_clock_in1), .ext_clock_in2(ext_clock_in2));
   tcc_pins u_pins (.pclk(pclk), .line_a_out(line_a_out), .line_a_oe(line_a_oe),
      .line_b_out(line_b_out), .line_b_oe(line_b_oe), .line_a_in(line_a_in),
      .line_b_in(line_b_in), .ext_clock_in0(ext_clock_in0),
      .ext_clock_in1(ext_clock_in1), .ext_clock_in2(ext_clock_in2));

   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   task automatic final_report;
      if (err_total == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : final_report

   // The whole run needs under 1500 cycles
   always @(posedge pclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         err_total++;
         final_report();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // One APB transfer; entered just after a rising edge, idles one edge after
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 50)
      begin
         @(posedge pclk);
         n++;
      end
      rdat = prdata;
      rerr = pslverr;
      if (n >= 50)
         err_total++;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic clk_st(input logic e);
      apb(1'b0, tcc_pkg::ADDR_STAT, 32'h0);
      chk({31'h0, rdat[tcc_pkg::ST_CLKSTA]}, {31'h0, e});
   endtask : clk_st

   task automatic t_regs;
      apb(1'b0, tcc_pkg::ADDR_MODE, 32'h0);
      chk(rdat, tcc_pkg::MODE_RST);
      apb(1'b0, tcc_pkg::ADDR_CMD, 32'h0);
      chk({rdat[30:0], rerr}, 32'h0);
      clk_st(1'b0);
      apb(1'b0, 8'h3c, 32'h0);
      chk({31'h0, rerr}, 32'h1);
      apb(1'b1, tcc_pkg::ADDR_RA, 32'h5);
      chk({31'h0, rerr}, 32'h1);
      apb(1'b1, tcc_pkg::ADDR_MODE, 32'hc3f5_7bde);
      apb(1'b0, tcc_pkg::ADDR_MODE, 32'h0);
      chk(rdat, 32'hc3f5_7bde);
   endtask : t_regs

   task automatic t_cmd;
      logic [15:0] c1;
      apb(1'b1, tcc_pkg::ADDR_MODE, 32'h0);
      apb(1'b1, tcc_pkg::ADDR_CMD, 32'h1);
      clk_st(1'b1);
      apb(1'b1, tcc_pkg::ADDR_CMD, 32'h0);
      clk_st(1'b1);
      apb(1'b1, tcc_pkg::ADDR_CMD, 32'h2);
      clk_st(1'b0);
      apb(1'b1, tcc_pkg::ADDR_CMD, 32'h3);
      clk_st(1'b0);
      apb(1'b1, tcc_pkg::ADDR_CMD, 32'h1);
      repeat (100) @(posedge pclk);
      apb(1'b0, tcc_pkg::ADDR_CNT, 32'h0);
      c1 = rdat[15:0];
      apb(1'b1, tcc_pkg::ADDR_CMD, 32'h4);
      apb(1'b0, tcc_pkg::ADDR_CNT, 32'h0);
      chk({30'h0, c1 > 16'h20, rdat[15:0] < 16'h8}, 32'h3);
   endtask : t_cmd

   task automatic t_capture;
      logic [15:0] ra;
      apb(1'b1, tcc_pkg::ADDR_MODE, 32'h0009_0080);
      apb(1'b1, tcc_pkg::ADDR_CMD, 32'h5);
      repeat (20) @(posedge pclk);
      u_pins.set_a(1'b1);
      repeat (20) @(posedge pclk);
      u_pins.set_a(1'b0);
      repeat (20) @(posedge pclk);
      apb(1'b0, tcc_pkg::ADDR_RA, 32'h0);
      ra = rdat[15:0];
      apb(1'b0, tcc_pkg::ADDR_RB, 32'h0);
      chk({30'h0, ra != 16'h0, rdat[15:0] > ra}, 32'h3);
      clk_st(1'b0);
      // Rising edge of line A as capture trigger; counter is far above the limit before it
      apb(1'b1, tcc_pkg::ADDR_MODE, 32'h0000_0500);
      apb(1'b1, tcc_pkg::ADDR_CMD, 32'h1);
      repeat (60) @(posedge pclk);
      u_pins.set_a(1'b1);
      repeat (10) @(posedge pclk);
      apb(1'b0, tcc_pkg::ADDR_CNT, 32'h0);
      chk({31'h0, rdat[15:0] < 16'h10}, 32'h1);
      u_pins.set_a(1'b0);
   endtask : t_capture

   task automatic t_wave_out;
      apb(1'b1, tcc_pkg::ADDR_MODE, 32'h8080_8400);
      apb(1'b1, tcc_pkg::ADDR_CMD, 32'h4);
      repeat (3) @(posedge pclk);
      chk({28'h0, line_a_oe, line_b_oe, line_a_out, line_b_out}, 32'hc);
      ea = 1'b0;
      for (int e = 0; e < 4; e++)
      begin
         apb(1'b1, tcc_pkg::ADDR_MODE, 32'h8400 | (e << 22) | (e << 30));
         apb(1'b1, tcc_pkg::ADDR_CMD, 32'h4);
         repeat (3) @(posedge pclk);
         ea = (e == 1) ? 1'b1 : (e == 2) ? 1'b0 : (e == 3) ? ~ea : ea;
         chk({30'h0, line_a_out, line_b_out}, {30'h0, ea, ea});
      end
      apb(1'b1, tcc_pkg::ADDR_MODE, 32'h8000);
      repeat (2) @(posedge pclk);
      chk({31'h0, line_b_oe}, 32'h0);
   endtask : t_wave_out

   task automatic t_event;
      logic [15:0] c1;
      apb(1'b1, tcc_pkg::ADDR_MODE, 32'h0030_8500);
      apb(1'b1, tcc_pkg::ADDR_CMD, 32'h1);
      repeat (60) @(posedge pclk);
      apb(1'b0, tcc_pkg::ADDR_CNT, 32'h0);
      c1 = rdat[15:0];
      u_pins.pulse_x(0, 1, 8);
      apb(1'b0, tcc_pkg::ADDR_CNT, 32'h0);
      ea = ~ea;
      chk({30'h0, rdat[15:0] > c1, line_a_out}, {30'h0, 1'b1, ea});
      apb(1'b1, tcc_pkg::ADDR_MODE, 32'h0030_9500);
      u_pins.pulse_x(0, 1, 8);
      apb(1'b0, tcc_pkg::ADDR_CNT, 32'h0);
      ea = ~ea;
      chk({30'h0, rdat[15:0] < 16'h10, line_a_out}, {30'h0, 1'b1, ea});
   endtask : t_event

   task automatic t_stop;
      logic [15:0] c1;
      apb(1'b1, tcc_pkg::ADDR_MODE, 32'h8040);
      apb(1'b1, tcc_pkg::ADDR_RC, 32'd20);
      apb(1'b1, tcc_pkg::ADDR_CMD, 32'h5);
      repeat (80) @(posedge pclk);
      apb(1'b0, tcc_pkg::ADDR_STAT, 32'h0);
      chk({30'h0, rdat[tcc_pkg::ST_STOP], rdat[tcc_pkg::ST_CLKSTA]}, 32'h3);
      apb(1'b0, tcc_pkg::ADDR_CNT, 32'h0);
      c1 = rdat[15:0];
      repeat (10) @(posedge pclk);
      apb(1'b0, tcc_pkg::ADDR_CNT, 32'h0);
      chk({16'h0, rdat[15:0]}, {16'h0, c1});
      apb(1'b1, tcc_pkg::ADDR_CMD, 32'h4);
      apb(1'b0, tcc_pkg::ADDR_STAT, 32'h0);
      chk({30'h0, rdat[tcc_pkg::ST_STOP], rdat[tcc_pkg::ST_CLKSTA]}, 32'h1);
      apb(1'b1, tcc_pkg::ADDR_CMD, 32'h2);
      apb(1'b1, tcc_pkg::ADDR_CMD, 32'h4);
      clk_st(1'b0);
      apb(1'b1, tcc_pkg::ADDR_MODE, 32'h8080);
      apb(1'b1, tcc_pkg::ADDR_CMD, 32'h5);
      repeat (80) @(posedge pclk);
      clk_st(1'b0);
   endtask : t_stop

   task automatic t_clock_src;
      apb(1'b1, tcc_pkg::ADDR_MODE, 32'h10);
      apb(1'b1, tcc_pkg::ADDR_CMD, 32'h5);
      repeat (20) @(posedge pclk);
      apb(1'b0, tcc_pkg::ADDR_CNT, 32'h0);
      chk(rdat, 32'h0);
      apb(1'b1, tcc_pkg::ADDR_MODE, 32'h5);
      apb(1'b1, tcc_pkg::ADDR_CMD, 32'h5);
      u_pins.pulse_x(0, 4, 8);
      apb(1'b0, tcc_pkg::ADDR_CNT, 32'h0);
      chk(rdat, 32'h4);
   endtask : t_clock_src

   // Up-down with compare C: a trigger turns the count, the count turns at C
   task automatic t_updown;
      logic [15:0] c1;
      apb(1'b1, tcc_pkg::ADDR_MODE, 32'h8002);
      apb(1'b1, tcc_pkg::ADDR_CMD, 32'h5);
      apb(1'b1, tcc_pkg::ADDR_MODE, 32'he002);
      repeat (160) @(posedge pclk);
      apb(1'b0, tcc_pkg::ADDR_CNT, 32'h0);
      c1 = rdat[15:0];
      apb(1'b1, tcc_pkg::ADDR_CMD, 32'h4);
      repeat (100) @(posedge pclk);
      apb(1'b0, tcc_pkg::ADDR_CNT, 32'h0);
      chk({31'h0, rdat[15:0] < c1}, 32'h1);
      apb(1'b1, tcc_pkg::ADDR_MODE, 32'he000);
      repeat (200) @(posedge pclk);
      apb(1'b0, tcc_pkg::ADDR_CNT, 32'h0);
      chk({31'h0, rdat[15:0] <= 16'd20}, 32'h1);
   endtask : t_updown

   initial
   begin
      presetn   = 1'b0;
      psel      = 1'b0;
      penable   = 1'b0;
      pwrite    = 1'b0;
      paddr     = 8'h00;
      pwdata    = 32'h0;
      err_total = 0;
      n_tests   = 0;
      cycles    = 0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_regs();
      t_cmd();
      t_capture();
      t_wave_out();
      t_event();
      t_stop();
      t_clock_src();
      t_updown();
      final_report();
   end
endmodule : tcc_top_tb
